/* lane_status_pkg.sv */
// Summary of operation
// - spacing error bit per lane high while markers arrive off the configured period
// - repeat error bit set after four consecutive marker errors, held until cleared
// - malformed marker bit pulses one cycle per bad marker word, back to back allowed
// - aligned output high only while every lane is aligned and de-skewed
// - aligned low means local fault; fault output follows it
// - pcs status high only when aligned and not in high error rate state
// - block lock vector bit high while that lane holds block lock
// - alignment error level high on alignment failure or loss of alignment
// - no misalignment pulse until markers seen on all lanes and one bad marker follows
// - misalignment pulse comes one meta-frame after the causing marker error
// - no misalignment pulse if markers never received correctly on all lanes
// - misalignment is a one-cycle pulse; further errors before it is due restart the wait and give one pulse
package lane_status_pkg;
    localparam int          NUM_LANES       = 20;
    localparam int          PERIOD_W        = 16;
    localparam int          REPEAT_W        = 3;
    localparam logic [2:0]  REPEAT_LIMIT    = 3'h4;
    localparam logic [15:0] PERIOD_DEFAULT  = 16'h3FFF;
    localparam int          SYNC_STAGES     = 3;
    localparam int          INT_W           = 5;
    localparam logic [4:0]  INT_BIT_MISALIGN = 5'h01;
    localparam int          INT_MISALIGN    = 0;
    localparam int          INT_ALIGN_ERR   = 1;
    localparam int          INT_SPACING     = 2;
    localparam int          INT_REPEAT      = 3;
    localparam int          INT_MALFORMED   = 4;
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;
    localparam logic [3:0]  ADDR_STATUS     = 4'h1;
    localparam logic [3:0]  ADDR_INT_STAT   = 4'h2;
    localparam logic [3:0]  ADDR_INT_MASK   = 4'h3;
    localparam logic [3:0]  ADDR_BLOCK_LOCK = 4'h4;
    localparam logic [3:0]  ADDR_SPACING    = 4'h5;
    localparam logic [3:0]  ADDR_REPEAT     = 4'h6;
    localparam logic [3:0]  ADDR_ALIGNED_LN = 4'h7;
    localparam logic [31:0] READ_UNMAPPED   = 32'h0000_0000;
    typedef enum logic [2:0] {
        ALIGN_IDLE    = 3'b001,
        ALIGN_LOCKED  = 3'b010,
        ALIGN_LOST    = 3'b100
    } align_state_t;
endpackage : lane_status_pkg

/* lane_marker_check.sv */
`timescale 1ns/10ps
// per-lane marker spacing and repeat error tracking
module lane_marker_check
    import lane_status_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // marker events of one lane
    input  wire logic                marker_seen,
    input  wire logic                marker_bad,
    input  wire logic                word_valid,
    input  wire logic [PERIOD_W-1:0] marker_period_setting,
    // status
    output logic                     spacing_err,
    output logic                     repeat_err
);
    logic [PERIOD_W-1:0] word_count;
    logic [REPEAT_W-1:0] bad_run;
    logic                started;

    // words since the last marker; the setting is period minus one
    always_ff @(posedge clk) begin
        if (rst) begin
            word_count <= '0;
            started    <= 1'b0;
        end else if (marker_seen) begin
            word_count <= '0;
            started    <= 1'b1;
        end else if (word_valid && started) begin
            word_count <= word_count + 1'b1;
        end
    end

    // spacing error updates at each marker, so it clears on the next good one
    always_ff @(posedge clk) begin
        if (rst) begin
            spacing_err <= 1'b0;
        end else if (marker_seen && started) begin
            spacing_err <= (word_count != marker_period_setting);
        end else if (started && word_valid && word_count == marker_period_setting) begin
            spacing_err <= 1'b1;
        end
    end

    // run of bad markers; saturates so the level holds until a good marker
    always_ff @(posedge clk) begin
        if (rst) begin
            bad_run <= '0;
        end else if (marker_seen && marker_bad) begin
            if (bad_run != REPEAT_LIMIT) begin
                bad_run <= bad_run + 1'b1;
            end
        end else if (marker_seen) begin
            bad_run <= '0;
        end
    end

    assign repeat_err = (bad_run == REPEAT_LIMIT);

    chk_repeat_after_four : assert property (@(posedge clk) disable iff (rst)
        (marker_seen && marker_bad) [*1] ##0 (bad_run == 3'h3) |=> repeat_err)
        else $error("repeat error not set after four bad markers");
endmodule : lane_marker_check

/* misalign_timer.sv */
`timescale 1ns/10ps
// delays a marker error by one meta-frame before pulsing
module misalign_timer
    import lane_status_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // trigger
    input  wire logic                trigger,
    input  wire logic                word_valid,
    input  wire logic [PERIOD_W-1:0] marker_period_setting,
    // pulse
    output logic                     pulse
);
    logic [PERIOD_W-1:0] remain;
    logic                armed;

    // one pending error at a time; a later trigger restarts the frame wait
    always_ff @(posedge clk) begin
        if (rst) begin
            armed  <= 1'b0;
            remain <= '0;
            pulse  <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (trigger) begin
                // a pulse falling due now still goes out, so errors every frame keep pulsing
                armed  <= 1'b1;
                remain <= marker_period_setting;
                pulse  <= armed && word_valid && remain == '0;
            end else if (armed && word_valid) begin
                if (remain == '0) begin
                    armed <= 1'b0;
                    pulse <= 1'b1;
                end else begin
                    remain <= remain - 1'b1;
                end
            end
        end
    end
endmodule : misalign_timer

/* pcs_rx_lane_align_status.sv */
`timescale 1ns/10ps
module pcs_rx_lane_align_status
    import lane_status_pkg::*;
(
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            rst,
    // lane events from the marker datapath, bit i is lane i
    input  wire logic [lane_status_pkg::NUM_LANES-1:0] lane_marker_seen,
    input  wire logic [lane_status_pkg::NUM_LANES-1:0] lane_marker_bad,
    input  wire logic [lane_status_pkg::NUM_LANES-1:0] lane_block_lock_in,
    input  wire logic [lane_status_pkg::NUM_LANES-1:0] lane_deskewed,
    input  wire logic                            word_valid,
    input  wire logic                            high_error_rate_state,
    // register port
    input  wire logic [3:0]                      reg_addr,
    input  wire logic [31:0]                     reg_wdata,
    input  wire logic                            reg_write,
    input  wire logic                            reg_read,
    output logic [31:0]                          reg_rdata,
    // status outputs
    output logic [lane_status_pkg::NUM_LANES-1:0] lane_marker_spacing_err,
    output logic [lane_status_pkg::NUM_LANES-1:0] lane_marker_repeat_err,
    output logic [lane_status_pkg::NUM_LANES-1:0] lane_marker_malformed_err,
    output logic [lane_status_pkg::NUM_LANES-1:0] block_lock,
    output logic                                 all_lanes_aligned,
    output logic                                 local_fault,
    output logic                                 pcs_status,
    output logic                                 align_err,
    output logic                                 misaligned,
    output logic                                 irq
);
    import lane_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // configuration
    logic [PERIOD_W-1:0]  marker_period_setting;
    logic [INT_W-1:0]     int_status;
    logic [INT_W-1:0]     int_mask;
    logic [NUM_LANES-1:0] marker_ever;
    logic                 all_seen;
    logic                 aligned_now;
    logic                 misalign_trigger;
    logic                 stat_read;
    logic [INT_W-1:0]     events;
    align_state_t         align_state;

    // period setting; marker period minus one words
    always_ff @(posedge clk) begin
        if (rst) begin
            marker_period_setting <= PERIOD_DEFAULT;
        end else if (reg_write && reg_addr == ADDR_CTRL) begin
            marker_period_setting <= reg_wdata[PERIOD_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-lane checks, one instance per lane so index i stays lane i
    generate
        for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
            lane_marker_check u_check (
                .clk                   (clk),
                .rst                   (rst),
                .marker_seen           (lane_marker_seen[i]),
                .marker_bad            (lane_marker_bad[i]),
                .word_valid            (word_valid),
                .marker_period_setting (marker_period_setting),
                .spacing_err           (lane_marker_spacing_err[i]),
                .repeat_err            (lane_marker_repeat_err[i])
            );
        end
    endgenerate

    // one-cycle malformed pulses and block lock, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            lane_marker_malformed_err <= '0;
            block_lock                <= '0;
        end else begin
            lane_marker_malformed_err <= lane_marker_seen & lane_marker_bad;
            block_lock                <= lane_block_lock_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alignment tracking
    // a lane counts as seen once a good marker has arrived on it
    always_ff @(posedge clk) begin
        if (rst) begin
            marker_ever <= '0;
        end else begin
            marker_ever <= marker_ever | (lane_marker_seen & ~lane_marker_bad);
        end
    end

    assign all_seen    = &marker_ever;
    assign aligned_now = all_seen && (&lane_deskewed) && (&lane_block_lock_in);

    // alignment state machine; loss is remembered until alignment returns
    always_ff @(posedge clk) begin
        if (rst) begin
            align_state <= ALIGN_IDLE;
        end else begin
            case (align_state)
                ALIGN_IDLE: begin
                    if (aligned_now) begin
                        align_state <= ALIGN_LOCKED;
                    end
                end
                ALIGN_LOCKED: begin
                    if (!aligned_now) begin
                        align_state <= ALIGN_LOST;
                    end
                end
                ALIGN_LOST: begin
                    if (aligned_now) begin
                        align_state <= ALIGN_LOCKED;
                    end
                end
                default: begin
                    align_state <= ALIGN_IDLE;
                end
            endcase
        end
    end

    // level outputs from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            all_lanes_aligned <= 1'b0;
            local_fault       <= 1'b1;
            pcs_status        <= 1'b0;
            align_err         <= 1'b0;
        end else begin
            all_lanes_aligned <= aligned_now;
            local_fault       <= !aligned_now;
            pcs_status        <= aligned_now && !high_error_rate_state;
            // idle with any lane spacing error, or a lost alignment
            align_err <= (align_state == ALIGN_LOST && !aligned_now) ||
                         (align_state == ALIGN_LOCKED && !aligned_now) ||
                         (align_state == ALIGN_IDLE && |lane_marker_spacing_err);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // misalignment: armed only after markers seen on all lanes
    assign misalign_trigger = all_seen && |(lane_marker_seen & lane_marker_bad);

    misalign_timer u_timer (
        .clk                   (clk),
        .rst                   (rst),
        .trigger               (misalign_trigger),
        .word_valid            (word_valid),
        .marker_period_setting (marker_period_setting),
        .pulse                 (misaligned)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, cleared by reading the interrupt status register
    assign events    = {|lane_marker_malformed_err, |lane_marker_repeat_err,
                        |lane_marker_spacing_err, align_err, misaligned};
    assign stat_read = reg_read && reg_addr == ADDR_INT_STAT;

    // set wins over the read clear
    always_ff @(posedge clk) begin
        if (rst) begin
            int_status <= '0;
        end else if (stat_read) begin
            int_status <= events;
        end else begin
            int_status <= int_status | events;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            int_mask <= '0;
        end else if (reg_write && reg_addr == ADDR_INT_MASK) begin
            int_mask <= reg_wdata[INT_W-1:0];
        end
    end

    assign irq = |(int_status & int_mask);

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_CTRL:       reg_rdata <= {16'h0000, marker_period_setting};
                ADDR_STATUS:     reg_rdata <= {28'h000_0000, align_err, pcs_status,
                                               local_fault, all_lanes_aligned};
                ADDR_INT_STAT:   reg_rdata <= {27'h000_0000, int_status};
                ADDR_INT_MASK:   reg_rdata <= {27'h000_0000, int_mask};
                ADDR_BLOCK_LOCK: reg_rdata <= {12'h000, block_lock};
                ADDR_SPACING:    reg_rdata <= {12'h000, lane_marker_spacing_err};
                ADDR_REPEAT:     reg_rdata <= {12'h000, lane_marker_repeat_err};
                ADDR_ALIGNED_LN: reg_rdata <= {12'h000, marker_ever};
                default:         reg_rdata <= READ_UNMAPPED;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_malformed_pulse : assert property (@(posedge clk) disable iff (rst)
        (lane_marker_seen[0] && lane_marker_bad[0]) |=> lane_marker_malformed_err[0])
        else $error("malformed pulse missing");
    chk_malformed_single : assert property (@(posedge clk) disable iff (rst)
        !(lane_marker_seen[0] && lane_marker_bad[0]) |=> !lane_marker_malformed_err[0])
        else $error("malformed pulse without cause");
    chk_aligned_level : assert property (@(posedge clk) disable iff (rst)
        all_lanes_aligned |-> $past(&lane_deskewed))
        else $error("aligned while a lane not deskewed");
    chk_fault_follows : assert property (@(posedge clk) disable iff (rst)
        local_fault == !all_lanes_aligned)
        else $error("local fault not following alignment");
    chk_status_ber : assert property (@(posedge clk) disable iff (rst)
        pcs_status |-> all_lanes_aligned && !$past(high_error_rate_state))
        else $error("status high in high error rate state");
    chk_block_lock : assert property (@(posedge clk) disable iff (rst)
        ##1 block_lock == $past(lane_block_lock_in))
        else $error("block lock vector wrong");
    chk_loss_err : assert property (@(posedge clk) disable iff (rst)
        (align_state == ALIGN_LOCKED && !aligned_now) |=> align_err)
        else $error("alignment loss not flagged");
    chk_misalign_gate : assert property (@(posedge clk) disable iff (rst)
        !all_seen |-> !misaligned)
        else $error("misaligned before markers seen");
    chk_misalign_late : assert property (@(posedge clk) disable iff (rst)
        (misalign_trigger && !u_timer.armed) |=> !misaligned)
        else $error("misaligned in error cycle");
    chk_misalign_width : assert property (@(posedge clk) disable iff (rst)
        misaligned |=> !misaligned || $past(misalign_trigger, 1) == 1'b0)
        else $error("misaligned pulse too long");
    cov_aligned  : cover property (@(posedge clk) disable iff (rst) $rose(all_lanes_aligned));
    cov_misalign : cover property (@(posedge clk) disable iff (rst) misaligned);
    cov_repeat   : cover property (@(posedge clk) disable iff (rst) |lane_marker_repeat_err);
endmodule : pcs_rx_lane_align_status

/* remote_tx_model.sv */
`timescale 1ns/10ps
// far-end transmitter: every lane sends one marker per meta-frame
module remote_tx_model
    import lane_status_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // control from the bench
    input  wire logic                 run,
    input  wire logic [PERIOD_W-1:0]  gap,
    input  wire logic [NUM_LANES-1:0] bad_lanes,
    // lane events toward the receiver
    output logic      [NUM_LANES-1:0] seen,
    output logic      [NUM_LANES-1:0] bad,
    output logic                      word_valid
);
    logic [PERIOD_W-1:0] cnt;

    // all lanes mark in the same word; >= copes with a gap cut below cnt
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt        <= '0;
            seen       <= '0;
            word_valid <= 1'b0;
        end else begin
            word_valid <= 1'b1;
            cnt        <= (cnt >= gap) ? '0 : cnt + 1'b1;
            seen       <= (cnt >= gap) ? '1 : '0;
        end
    end

    // bad means nothing without seen, so it carries noise in between
    always_ff @(posedge clk) begin
        bad <= (run && cnt >= gap) ? bad_lanes : NUM_LANES'($urandom);
    end
endmodule : remote_tx_model

/* tb.sv */
`timescale 1ns/10ps
// bench: the model feeds the lanes, tasks speak the register port
module tb;
    import lane_status_pkg::*;
    typedef struct {string n; logic [31:0] v; logic [31:0] m; int at;} note_t;
    localparam logic [15:0] P = 16'h000F;  // short meta-frame keeps the run brief
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 run = 1'b0;
    logic                 arm = 1'b0;
    logic                 high_error_rate_state = 1'b0;
    logic [15:0]          gap = P;
    logic [3:0]           reg_addr = '0;
    logic [31:0]          reg_wdata = '0;
    logic                 reg_write = 1'b0;
    logic                 reg_read = 1'b0;
    logic                 rd_seen = 1'b0;
    logic [NUM_LANES-1:0] lock_in = '0;
    logic [NUM_LANES-1:0] deskew = '0;
    logic [NUM_LANES-1:0] bad_lanes = '0;
    logic [NUM_LANES-1:0] seen, bad_in, spc, rep, mal, blk, lock;
    logic [31:0]          reg_rdata;
    logic                 wv, aligned, fault, pstat, aerr, mis, irq;
    int                   cyc = 0;
    int                   bad_count = 0;
    int                   checked = 0;
    int                   lane;
    note_t                rq[$], mq[$], aq[$];
    note_t                e;

    always #25 clk = ~clk;

    remote_tx_model far (.clk(clk), .rst(rst), .run(run), .gap(gap), .bad_lanes(bad_lanes),
        .seen(seen), .bad(bad_in), .word_valid(wv));

    pcs_rx_lane_align_status dut (.clk(clk), .rst(rst), .lane_marker_seen(seen),
        .lane_marker_bad(bad_in), .lane_block_lock_in(lock_in), .lane_deskewed(deskew),
        .word_valid(wv), .high_error_rate_state(high_error_rate_state),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .lane_marker_spacing_err(spc),
        .lane_marker_repeat_err(rep), .lane_marker_malformed_err(mal), .block_lock(blk),
        .all_lanes_aligned(aligned), .local_fault(fault), .pcs_status(pstat),
        .align_err(aerr), .misaligned(mis), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : reg_wr

    // the read data are compared by the watcher, one cycle later
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] v, input logic [31:0] m,
                          input string n);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        rq.push_back(note_t'{n, v, m, 0});
        @(posedge clk);
        reg_read <= 1'b0;
    endtask : reg_rd

    task automatic frames(input int n);
        repeat (n * (int'(P) + 1)) @(posedge clk);
    endtask : frames

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    // read strobe seen by the slave, so data stand in the next cycle
    always @(posedge clk) begin
        cyc     <= cyc + 1;
        rd_seen <= reg_read;
    end

    // notes what the lanes were sent, then compares every result that shows
    always @(negedge clk) begin
        if (|(seen & bad_in)) begin
            mq.push_back(note_t'{"malformed", 32'(seen & bad_in), '1, cyc + 1});
            if (arm) aq.push_back(note_t'{"misaligned", 32'h1, '1, cyc + int'(P) + 2});
        end
        if (rd_seen) begin
            e = rq.pop_front();
            chk(e.n, e.v & e.m, reg_rdata & e.m);
        end
        if (mal != '0) begin
            e = mq.size() ? mq.pop_front() : note_t'{"malformed", 32'h0, '1, 0};
            chk(e.n, e.v, 32'(mal));
            chk("malformed_at", e.at, cyc);
        end
        if (mis) begin
            e = aq.size() ? aq.pop_front() : note_t'{"misaligned", 32'h0, '1, 0};
            chk(e.n, e.v, 32'(mis));
            chk("misaligned_at", e.at, cyc);
        end
    end

    // a hang costs a mismatch; the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h653fdc11));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("local_fault", 1, fault);
        chk("aligned", 0, aligned);
        reg_rd(ADDR_CTRL, {16'h0000, PERIOD_DEFAULT}, '1, "ctrl_reset");
        reg_rd(4'hF, READ_UNMAPPED, '1, "unmapped");
        reg_wr(ADDR_CTRL, {16'h0000, P});
        reg_rd(ADDR_CTRL, {16'h0000, P}, '1, "ctrl");
        reg_rd(ADDR_STATUS, 32'h0000_0002, 32'h0000_000F, "status_reset");
        $display("test reset finished");
        // one lane bad from the start: repeat error but never a misaligned pulse
        lane = $urandom_range(NUM_LANES - 1);
        @(posedge clk);
        bad_lanes <= NUM_LANES'(1) << lane;
        run       <= 1'b1;
        frames(6);
        @(negedge clk);
        chk("repeat_set", NUM_LANES'(1) << lane, rep);
        reg_rd(ADDR_REPEAT, 32'h1 << lane, '1, "repeat_reg");
        reg_rd(ADDR_ALIGNED_LN, 32'h000F_FFFF ^ (32'h1 << lane), '1, "seen_part");
        @(posedge clk);
        bad_lanes <= '0;
        frames(2);
        @(negedge clk);
        chk("repeat_clear", 0, rep);
        reg_rd(ADDR_ALIGNED_LN, 32'h000F_FFFF, '1, "seen_all");
        $display("test repeat finished");
        @(posedge clk);
        lock_in <= '1;
        deskew  <= '1;
        frames(2);
        @(negedge clk);
        chk("aligned_up", 1, aligned);
        chk("fault_down", 0, fault);
        chk("status_up", 1, pstat);
        chk("align_err_low", 0, aerr);
        reg_rd(ADDR_STATUS, 32'h0000_0005, 32'h0000_000F, "status_reg");
        @(posedge clk);
        high_error_rate_state <= 1'b1;
        repeat (3) @(negedge clk);
        chk("status_hber", 0, pstat);
        chk("aligned_hber", 1, aligned);
        @(posedge clk);
        high_error_rate_state <= 1'b0;
        $display("test status finished");
        // only the misaligned event is left unmasked
        reg_wr(ADDR_INT_MASK, {27'h000_0000, INT_BIT_MISALIGN});
        reg_rd(ADDR_INT_STAT, 32'h0000_0018, 32'h0000_001F, "int_flush");
        @(negedge clk);
        chk("irq_quiet", 0, irq);
        @(posedge clk);
        arm       <= 1'b1;
        bad_lanes <= NUM_LANES'(1) << $urandom_range(NUM_LANES - 1);
        frames(1);
        bad_lanes <= '0;
        frames(2);
        @(negedge clk);
        chk("irq_set", 1, irq);
        reg_rd(ADDR_INT_STAT, 32'h0000_0011, 32'h0000_0011, "int_stat");
        reg_rd(ADDR_INT_STAT, 32'h0, 32'h0000_0011, "int_clear");
        @(negedge clk);
        chk("irq_clear", 0, irq);
        arm <= 1'b0;
        $display("test misalign finished");
        // markers two words late on every lane, then back on time
        @(posedge clk);
        gap <= P + 16'h0002;
        frames(3);
        @(negedge clk);
        chk("spacing_set", 32'h000F_FFFF, spc);
        reg_rd(ADDR_SPACING, 32'h000F_FFFF, 32'h000F_FFFF, "spacing_reg");
        @(posedge clk);
        gap <= P;
        frames(3);
        @(negedge clk);
        chk("spacing_clear", 0, spc);
        $display("test spacing finished");
        lock = NUM_LANES'($urandom) & ~(NUM_LANES'(1) << lane);
        @(posedge clk);
        lock_in <= lock;
        repeat (3) @(negedge clk);
        chk("block_lock", lock, blk);
        chk("aligned_lost", 0, aligned);
        chk("fault_lost", 1, fault);
        chk("align_err_lost", 1, aerr);
        reg_rd(ADDR_BLOCK_LOCK, 32'(lock), 32'h000F_FFFF, "lock_reg");
        repeat (2) @(negedge clk);
        chk("pending", 0, mq.size() + aq.size());
        $display("test lock finished");
        stop_test();
    end
endmodule : tb
